// ---- core/processor_port_and_reset.sv ----
/*
 * processor-side register port and reset behaviour of a parallel
 * interface adapter: sixteen byte registers, chip selects, read/write,
 * transfers paced by the phase-two clock pin.
 * assumes all pins are asynchronous to sys_clk_in (40 MHz) and that
 * the phase-two clock runs well below a quarter of that rate.
 */
// Overview of operation
// - reset zeroes registers except timers and shift
// - reset floats every peripheral and data bus pin
// - reset halts timers, shifter and interrupt logic
// - reset overrides every input pin value
// - four select lines pick one of sixteen
// - selected read drives addressed register onto bus
// - selected write stores bus into addressed register
// - access only when high select one, low zero
// - bus released whenever device is not selected
// - transfers are paced by phase-two clock
`timescale 1ns/1ps
`default_nettype none
module processor_port_and_reset
   import host_port_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic reset_low_input_in,
   input wire logic phase_two_clock_in,
   input wire logic select_high_input_in,
   input wire logic select_low_input_in,
   input wire logic read_write_line_in,
   input wire logic [SEL_W-1:0] register_select_lines_in,
   input wire logic [DATA_W-1:0] data_bus_lines_in,
   output logic [DATA_W-1:0] data_bus_lines_out,
   output logic data_bus_lines_oe_out,
   output logic [DATA_W-1:0] port_a_out,
   output logic [DATA_W-1:0] port_a_oe_out,
   output logic [DATA_W-1:0] port_b_out,
   output logic [DATA_W-1:0] port_b_oe_out,
   output logic timers_run_out,
   output logic shift_run_out,
   output logic irq_low_out
);

   // ***************************************************************
   // pin synchronisation
   // ***************************************************************
   logic [PIN_W-1:0] pins_raw;
   logic [PIN_W-1:0] pins_f;

   assign pins_raw = {reset_low_input_in, phase_two_clock_in,
                      select_high_input_in, select_low_input_in,
                      read_write_line_in, register_select_lines_in,
                      data_bus_lines_in};

   pin_filter #(.W(PIN_W)) u_filter (
      .clk_in(sys_clk_in),
      .rst_in(rst_in),
      .pin_in(pins_raw),
      .level_out(pins_f)
   );

   // ***************************************************************
   // reset condition and input gating
   // ***************************************************************
   wire pin_reset = ~pins_f[POS_RESET_LOW];
   wire run = ~pin_reset;
   // reset forces every gated input inactive
   wire phase_g = pins_f[POS_PHASE] & run;
   wire sel_high_g = pins_f[POS_SEL_HIGH] & run;
   wire sel_low_g = pins_f[POS_SEL_LOW] | pin_reset;
   wire rw_g = pins_f[POS_RW] & run;
   wire [SEL_W-1:0] index_g = pins_f[POS_SEL+:SEL_W] & {SEL_W{run}};
   wire [DATA_W-1:0] data_g = pins_f[POS_DATA+:DATA_W] & {DATA_W{run}};
   // both selects must be active at once
   wire chip_sel = sel_high_g & ~sel_low_g;

   // ***************************************************************
   // phase-two edges
   // ***************************************************************
   logic phase_q;
   wire phase_rise = phase_g & ~phase_q;
   wire phase_fall = ~phase_g & phase_q;

   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
         phase_q <= 1'b0;
      else
         phase_q <= phase_g;
   end

   // ***************************************************************
   // transfer state machine
   // ***************************************************************
   xfer_state_t state_q;
   xfer_state_t state_d;
   bus_req_t req_q;
   bus_req_t req_now;
   logic [DATA_W-1:0] wdata_q;

   // selects and direction are sampled together at the rising edge,
   // relying on the processor having set the selects first
   assign req_now = '{read: rw_g, selected: chip_sel, index: index_g};

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
         begin
            if (phase_rise && req_now.selected)
               state_d = req_now.read ? ST_READ : ST_WRITE;
         end
         ST_READ, ST_WRITE:
         begin
            if (phase_fall || !chip_sel)
               state_d = ST_IDLE;
         end
         default:
            state_d = ST_IDLE;
      endcase
   end

   // state, latched request and held write data
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_q <= ST_IDLE;
         req_q <= '0;
         wdata_q <= REG_RESET;
      end
      else
      begin
         state_q <= state_d;
         if (phase_rise)
            req_q <= req_now;
         if (phase_g)
            wdata_q <= data_g; // last value seen while phase two high
      end
   end

   // ***************************************************************
   // register decode
   // ***************************************************************
   // write strobe fires on the falling edge ending a write
   wire write_fire = (state_q == ST_WRITE) && phase_fall && chip_sel
                     && req_q.selected && !req_q.read;
   logic [REG_COUNT-1:0] hit;
   assign hit = REG_COUNT'(1) << req_q.index; // one of sixteen

   // timer counters, latches and shift register survive pin reset
   function automatic logic keeps_on_reset(input logic [3:0] idx);
      keeps_on_reset = ((idx >= IDX_TIMER1_FIRST) &&
                        (idx <= IDX_TIMER2_LAST)) ||
                       (idx == IDX_SHIFT);
   endfunction : keeps_on_reset

   // ***************************************************************
   // register array
   // ***************************************************************
   logic [DATA_W-1:0] regs_q [REG_COUNT];

   genvar r;
   generate
      for (r = 0; r < REG_COUNT; r++)
      begin : g_reg
         localparam logic [3:0] IDX = 4'(r);
         localparam logic KEEP = keeps_on_reset(IDX);
         // pin reset clears all but the timer and shift entries
         always_ff @(posedge sys_clk_in or posedge rst_in)
         begin
            if (rst_in)
               regs_q[r] <= REG_RESET;
            else if (pin_reset && !KEEP)
               regs_q[r] <= REG_RESET;
            else if (write_fire && hit[r])
               regs_q[r] <= wdata_q;
         end
      end
   endgenerate

   // ***************************************************************
   // read data path
   // ***************************************************************
   logic [DATA_W-1:0] rdata_q;

   // addressed register latched at the rising edge of a read
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
         rdata_q <= REG_RESET;
      else if (phase_rise && req_now.selected && req_now.read)
         rdata_q <= regs_q[req_now.index];
   end

   // drive only while a selected read is under way
   assign data_bus_lines_out = rdata_q;
   assign data_bus_lines_oe_out = (state_q == ST_READ) && req_q.read
                                  && chip_sel && phase_g;

   // ***************************************************************
   // peripheral side and engine enables
   // ***************************************************************
   // all peripheral pins are inputs while reset holds
   assign port_a_out = regs_q[IDX_PORT_A_OUT];
   assign port_b_out = regs_q[IDX_PORT_B_OUT];
   assign port_a_oe_out = regs_q[IDX_PORT_A_DIR] & {DATA_W{run}};
   assign port_b_oe_out = regs_q[IDX_PORT_B_DIR] & {DATA_W{run}};

   // timers, shifter and interrupt request held off in reset
   wire [6:0] irq_src = regs_q[IDX_IRQ_FLAG][6:0] &
                        regs_q[IDX_IRQ_ENABLE][6:0] & IRQ_SRC_MASK;
   assign timers_run_out = run;
   assign shift_run_out = run;
   assign irq_low_out = ~(run & (|irq_src));

endmodule : processor_port_and_reset
`default_nettype wire

// ---- core/host_port_pkg.sv ----
/*
 * constants and types for the processor port and reset block.
 * assumes a single system clock; all pins arrive asynchronously.
 */
package host_port_pkg;

   // ***************************************************************
   // widths and register indices
   // ***************************************************************
   localparam int DATA_W = 8;
   localparam int SEL_W = 4;
   localparam int REG_COUNT = 16;
   localparam int PIN_W = 17;

   localparam logic [3:0] IDX_PORT_B_OUT = 4'h0;
   localparam logic [3:0] IDX_PORT_A_OUT = 4'h1;
   localparam logic [3:0] IDX_PORT_B_DIR = 4'h2;
   localparam logic [3:0] IDX_PORT_A_DIR = 4'h3;
   localparam logic [3:0] IDX_TIMER1_FIRST = 4'h4;
   localparam logic [3:0] IDX_TIMER1_LAST = 4'h7;
   localparam logic [3:0] IDX_TIMER2_FIRST = 4'h8;
   localparam logic [3:0] IDX_TIMER2_LAST = 4'h9;
   localparam logic [3:0] IDX_SHIFT = 4'hA;
   localparam logic [3:0] IDX_IRQ_FLAG = 4'hD;
   localparam logic [3:0] IDX_IRQ_ENABLE = 4'hE;

   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [6:0] IRQ_SRC_MASK = 7'h7F;

   // ***************************************************************
   // positions in the synchronised pin vector
   // ***************************************************************
   localparam int POS_DATA = 0;
   localparam int POS_SEL = 8;
   localparam int POS_RW = 12;
   localparam int POS_SEL_LOW = 13;
   localparam int POS_SEL_HIGH = 14;
   localparam int POS_PHASE = 15;
   localparam int POS_RESET_LOW = 16;

   // one access as latched at the rising phase-two edge
   typedef struct packed {
      logic read;
      logic selected;
      logic [SEL_W-1:0] index;
   } bus_req_t;

   // transfer state, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_READ = 3'b010,
      ST_WRITE = 3'b100
   } xfer_state_t;

endpackage : host_port_pkg

// ---- core/pin_filter.sv ----
/*
 * three-flop synchroniser with agreement filter, one lane per bit.
 * assumes pins are asynchronous to clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_filter
#(
   parameter int W = 1
)
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level_out
);

   // ***************************************************************
   // per bit: three stages, level moves when stages two and three agree
   // ***************************************************************
   genvar b;
   generate
      for (b = 0; b < W; b++)
      begin : g_lane
         logic s1_q;
         logic s2_q;
         logic s3_q;
         logic lvl_q;
         wire agree = (s2_q == s3_q);
         // stage one feeds stage two only
         always_ff @(posedge clk_in or posedge rst_in)
         begin
            if (rst_in)
            begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
               lvl_q <= 1'b0;
            end
            else
            begin
               s1_q <= pin_in[b];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (agree)
                  lvl_q <= s3_q;
            end
         end
         assign level_out[b] = lvl_q;
      end
   endgenerate

endmodule : pin_filter
`default_nettype wire

// ---- tb/host_bus_model.sv ----
/*
 * host processor model for the register port: selects, read/write,
 * index and data around a phase-two pulse of chosen length.
 * assumes the bench clock; the data bus has a level holder.
 */
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
   import host_port_pkg::*;
(
   input wire logic clk_in,
   input wire logic [DATA_W-1:0] dev_data_in,
   input wire logic dev_oe_in,
   output logic phase_out = 1'b0,
   output logic sel_high_out = 1'b0,
   output logic sel_low_out = 1'b1,
   output logic rw_out = 1'b1,
   output logic [SEL_W-1:0] index_out = 4'h0,
   output logic [DATA_W-1:0] bus_out
);
   logic [DATA_W-1:0] drv_q = 8'h00;
   logic drv_oe_q = 1'b0;
   logic [DATA_W-1:0] keep_q = 8'h00;
   // bus level: device, else host, else the holder's last level
   assign bus_out = dev_oe_in ? dev_data_in : drv_oe_q ? drv_q : keep_q;
   always @(posedge clk_in) keep_q <= bus_out;
   // one transfer; selects settle with read/write before phase two
   task automatic access(input logic rd, sh, sl, input logic [3:0] idx,
      input logic [7:0] wd, input int hi, output logic [7:0] q);
      @(posedge clk_in);
      sel_high_out <= sh;
      sel_low_out <= sl;
      rw_out <= rd;
      index_out <= idx;
      drv_q <= wd;
      drv_oe_q <= !rd;
      repeat (2) @(posedge clk_in);
      phase_out <= 1'b1;
      repeat (hi) @(posedge clk_in);
      q = bus_out;
      phase_out <= 1'b0;
      drv_oe_q <= 1'b0;
      repeat (6) @(posedge clk_in);
      sel_high_out <= 1'b0;
      sel_low_out <= 1'b1;
      repeat (2) @(posedge clk_in);
   endtask : access
endmodule : host_bus_model
`default_nettype wire

// ---- tb/processor_port_and_reset_asserts.sv ----
/*
 * port checker for the processor port block.
 * assumes the top module's port names; bound below.
 */
`timescale 1ns/1ps
`default_nettype none
module port_checker
   import host_port_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic reset_low_input_in,
   input wire logic phase_two_clock_in,
   input wire logic select_high_input_in,
   input wire logic select_low_input_in,
   input wire logic read_write_line_in,
   input wire logic data_bus_lines_oe_out,
   input wire logic [DATA_W-1:0] port_a_out,
   input wire logic [DATA_W-1:0] port_a_oe_out,
   input wire logic [DATA_W-1:0] port_b_out,
   input wire logic [DATA_W-1:0] port_b_oe_out,
   input wire logic timers_run_out,
   input wire logic shift_run_out,
   input wire logic irq_low_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   // ***************************************************************
   // pin reset and bus release
   // ***************************************************************
   reset_float_a: assert property (!reset_low_input_in [*7]
      |-> !data_bus_lines_oe_out && (port_a_oe_out | port_b_oe_out) == 8'h00)
      else $error("pins driven in reset");
   reset_halt_a: assert property (!reset_low_input_in [*7] |->
      !timers_run_out && !shift_run_out) else $error("units run in reset");
   irq_quiet_a: assert property (!reset_low_input_in [*7] |->
      irq_low_out) else $error("interrupt in reset");
   unsel_float_a: assert property ((!select_high_input_in ||
      select_low_input_in) [*7] |-> !data_bus_lines_oe_out)
      else $error("bus driven unselected");
   phase_float_a: assert property (!phase_two_clock_in [*7] |->
      !data_bus_lines_oe_out) else $error("bus driven phase low");
   write_float_a: assert property (!read_write_line_in [*7] |->
      !data_bus_lines_oe_out) else $error("bus driven on write");
   drive_cause_a: assert property ($rose(data_bus_lines_oe_out) |->
      phase_two_clock_in && select_high_input_in && !select_low_input_in &&
      read_write_line_in && reset_low_input_in) else $error("bad drive");
   ports_hold_a: assert property ((!phase_two_clock_in &&
      reset_low_input_in) [*8] |=> $stable(port_a_out) && $stable(port_b_out))
      else $error("port changed without write");
endmodule : port_checker
bind processor_port_and_reset port_checker port_checker_inst (.sys_clk_in,
   .rst_in, .reset_low_input_in, .phase_two_clock_in, .select_high_input_in,
   .select_low_input_in, .read_write_line_in, .data_bus_lines_oe_out,
   .port_a_out, .port_a_oe_out, .port_b_out, .port_b_oe_out,
   .timers_run_out, .shift_run_out, .irq_low_out);
`default_nettype wire

// ---- tb/testbench.sv ----
/*
 * self-checking bench: reference register array against the block.
 * assumes the host bus model and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import host_port_pkg::*;
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic reset_low_input_in = 1'b0;
   logic phase, sel_h, sel_l, rw, d_oe, t_run, s_run, irq_low;
   logic [3:0] idx;
   logic [7:0] bus, d_out, pa, pa_oe, pb, pb_oe, q;
   int mem[16];
   int n_fail = 0;
   int compares = 0;
   int cycles = 0;
   processor_port_and_reset processor_port_and_reset_inst (.sys_clk_in,
      .rst_in, .reset_low_input_in, .phase_two_clock_in(phase),
      .select_high_input_in(sel_h), .select_low_input_in(sel_l),
      .read_write_line_in(rw), .register_select_lines_in(idx),
      .data_bus_lines_in(bus), .data_bus_lines_out(d_out),
      .data_bus_lines_oe_out(d_oe), .port_a_out(pa), .port_a_oe_out(pa_oe),
      .port_b_out(pb), .port_b_oe_out(pb_oe), .timers_run_out(t_run),
      .shift_run_out(s_run), .irq_low_out(irq_low));
   host_bus_model host_bus_model_inst (.clk_in(sys_clk_in),
      .dev_data_in(d_out), .dev_oe_in(d_oe), .phase_out(phase),
      .sel_high_out(sel_h), .sel_low_out(sel_l), .rw_out(rw),
      .index_out(idx), .bus_out(bus));
   // clock and hang guard
   initial
   begin
      forever #12.5 sys_clk_in = ~sys_clk_in;
   end
   always @(posedge sys_clk_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         final_report();
      end
   end
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      compares++;
      if (s !== e)
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      if (s !== e)
         n_fail++;
   endtask : chk
   task automatic wr(input logic [3:0] i, input logic [7:0] d);
      host_bus_model_inst.access(1'b0, 1'b1, 1'b0, i, d, 6 + $urandom % 4, q);
      mem[i] = d;
   endtask : wr
   task automatic rd(input logic [3:0] i);
      host_bus_model_inst.access(1'b1, 1'b1, 1'b0, i, 8'h00, 7, q);
      chk(q, 8'(mem[i]));
   endtask : rd
   task automatic final_report();
      if (n_fail == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   // main sequence
   initial
   begin
      void'($urandom(32'h82e8));
      repeat (6) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      reset_low_input_in <= 1'b1;
      repeat (6) @(posedge sys_clk_in);
      for (int i = 0; i < 16; i++)
         if (i != 13 && i != 14) rd(4'(i));
      for (int i = 0; i < 16; i++)
         if (i != 13 && i != 14) wr(4'(i), 8'($urandom));
      for (int i = 0; i < 16; i++)
         if (i != 13 && i != 14) rd(4'(i));
      chk(pa, 8'(mem[1]));
      chk(pb, 8'(mem[0]));
      chk(pa_oe, 8'(mem[3]));
      chk(pb_oe, 8'(mem[2]));
      chk({6'h00, t_run, s_run}, 8'h03);
      host_bus_model_inst.access(1'b0, 1'b0, 1'b0, 4'h0, 8'hA5, 6, q);
      host_bus_model_inst.access(1'b0, 1'b1, 1'b1, 4'h0, 8'h5A, 6, q);
      rd(4'h0);
      wr(4'hE, 8'h01);
      wr(4'hD, 8'h01);
      chk({7'h00, irq_low}, 8'h00);
      reset_low_input_in <= 1'b0;
      repeat (8) @(posedge sys_clk_in);
      chk(pa_oe | pb_oe | {7'h00, d_oe}, 8'h00);
      chk({5'h00, t_run, s_run, irq_low}, 8'h01);
      host_bus_model_inst.access(1'b0, 1'b1, 1'b0, 4'h1, 8'hFF, 6, q);
      reset_low_input_in <= 1'b1;
      repeat (8) @(posedge sys_clk_in);
      for (int i = 0; i < 16; i++)
         if (i < 4 || i > 10) mem[i] = 0;
      for (int i = 0; i < 16; i++)
         if (i != 13 && i != 14) rd(4'(i));
      chk({7'h00, irq_low}, 8'h01);
      final_report();
   end
endmodule : testbench
`default_nettype wire
